// ---- alam_pkg.sv ----
// constants, codes and types shared by the limit alert monitor
`default_nettype none
package alam_pkg;
  // widths
  localparam int DATA_W = 12;
  localparam int NUM_CH = 2;
  localparam int LIM_N = 6;
  // register pointer codes
  localparam logic [3:0] PTR_RESULT = 4'h0;
  localparam logic [3:0] PTR_STATUS = 4'h1;
  localparam logic [3:0] PTR_CONFIG = 4'h2;
  localparam logic [3:0] PTR_CYCLE = 4'h3;
  localparam logic [3:0] PTR_LO_CH1 = 4'h4;
  localparam logic [3:0] PTR_HY_CH2 = 4'h9;
  // limit bank index layout: channel * 3 + kind
  localparam logic [2:0] KIND_LO = 3'h0;
  localparam logic [2:0] KIND_HI = 3'h1;
  localparam logic [2:0] KIND_HY = 3'h2;
  localparam logic [2:0] KIND_N = 3'h3;
  // configuration field positions
  localparam int CFG_POL = 0;
  localparam int CFG_ROLE_LO = 1;
  localparam int CFG_ROLE_HI = 2;
  localparam int CFG_FLTR = 3;
  localparam int CFG_SEL_LO = 4;
  localparam int CFG_SEL_HI = 6;
  localparam int CFG_W = 7;
  localparam logic [6:0] CFG_RST = 7'h08;
  // result word layout
  localparam int RES_FLAG_BIT = 15;
  localparam int RES_TAG_BIT = 12;
  // reset and special values
  localparam logic [11:0] LIM_HI_RST = 12'hFFF;
  localparam logic [11:0] LIM_LO_RST = 12'h000;
  localparam logic [11:0] HYST_RST = 12'h008;
  localparam logic [11:0] HYST_MINMAX = 12'hFFF;
  localparam logic [7:0] STATUS_CLR_ALL = 8'hFF;
  localparam logic [7:0] CYCLE_RST = 8'h00;
  // pin role codes
  typedef enum logic [1:0] {
    ROLE_NONE = 2'b00,
    ROLE_BUSY = 2'b01,
    ROLE_ALERT = 2'b10,
    ROLE_CLEAR = 2'b11
  } alam_role_t;
  // reference and input select codes
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_IN1_VDD = 3'b001,
    SEL_IN2_VDD = 3'b010,
    SEL_ALT = 3'b011,
    SEL_IN1_EXT = 3'b101
  } alam_sel_t;
endpackage
`default_nettype wire

// ---- alam_lim_if.sv ----
// carrier between the monitor and its limit register bank
`timescale 1ns/100ps
`default_nettype none
interface alam_lim_if #(parameter int W = 12);
  logic sel_ch; // channel whose triplet is fetched
  logic [W-1:0] hi; // fetched upper limit
  logic [W-1:0] lo; // fetched lower limit
  logic [W-1:0] hy; // fetched hysteresis
  logic wr_en; // register port write
  logic [2:0] wr_idx;
  logic [W-1:0] wr_data;
  logic upd_hi; // min/max tracking updates
  logic upd_lo;
  logic upd_ch;
  logic [W-1:0] upd_val;
  logic [2:0] rd_idx; // register port read
  logic [W-1:0] rd_data;
  modport bank (
    input sel_ch, wr_en, wr_idx, wr_data, upd_hi, upd_lo, upd_ch,
    input upd_val, rd_idx,
    output hi, lo, hy, rd_data
  );
  modport ctrl (
    output sel_ch, wr_en, wr_idx, wr_data, upd_hi, upd_lo, upd_ch,
    output upd_val, rd_idx,
    input hi, lo, hy, rd_data
  );
endinterface
`default_nettype wire

// ---- alam_lim_bank.sv ----
// six limit and hysteresis words with registered read ports
`timescale 1ns/100ps
`default_nettype none
module alam_lim_bank #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // bank side of the carrier
  alam_lim_if.bank lim
);
  logic [W-1:0] mem_q [alam_pkg::LIM_N]; // lo, hi, hy per channel
  logic [2:0] base_fetch; // first index of the fetched channel
  logic [2:0] base_upd; // first index of the tracked channel

  // elaboration check: bank words carry exactly one result value
  if (W != alam_pkg::DATA_W)
  begin : g_bad_width
    $error("bank width must match the result width");
  end

  assign base_fetch = lim.sel_ch ? alam_pkg::KIND_N : 3'h0;
  assign base_upd = lim.upd_ch ? alam_pkg::KIND_N : 3'h0;

  // one word per index: port write wins over tracking update
  for (genvar i = 0; i < alam_pkg::LIM_N; i++)
  begin : g_word
    localparam logic [2:0] IDX = 3'(i);
    localparam logic [2:0] KIND = 3'(i % 3);
    localparam logic [W-1:0] RST = (KIND == alam_pkg::KIND_HI) ?
      alam_pkg::LIM_HI_RST : (KIND == alam_pkg::KIND_HY) ?
      alam_pkg::HYST_RST : alam_pkg::LIM_LO_RST;
    logic hit_hi; // max tracking hits this word
    logic hit_lo; // min tracking hits this word
    assign hit_hi = lim.upd_hi && (IDX == base_upd + alam_pkg::KIND_HI);
    assign hit_lo = lim.upd_lo && (IDX == base_upd + alam_pkg::KIND_LO);
    always_ff @(posedge clk_sys)
    begin
      if (!rst_n)
        mem_q[i] <= RST;
      else if (lim.wr_en && lim.wr_idx == IDX)
        mem_q[i] <= lim.wr_data;
      else if (hit_hi || hit_lo)
        mem_q[i] <= lim.upd_val;
    end
  end

  // fetch the triplet of the incoming result's channel
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      lim.lo <= alam_pkg::LIM_LO_RST;
      lim.hi <= alam_pkg::LIM_HI_RST;
      lim.hy <= alam_pkg::HYST_RST;
      lim.rd_data <= '0;
    end
    else
    begin
      lim.lo <= mem_q[base_fetch + alam_pkg::KIND_LO];
      lim.hi <= mem_q[base_fetch + alam_pkg::KIND_HI];
      lim.hy <= mem_q[base_fetch + alam_pkg::KIND_HY];
      lim.rd_data <= (lim.rd_idx < 3'(alam_pkg::LIM_N)) ?
        mem_q[lim.rd_idx] : '0;
    end
  end
endmodule
`default_nettype wire

// ---- alam_monitor.sv ----
// limit alert monitor: configuration, result word, limits, pin
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - select bits choose input, reference, alternation
// - role bits: none, busy, or limit event
// - role write 11 clears pin, flag, status
// - after clear, role reads back as 10
// - result is 16-bit read-only straight binary
// - result: flag, two zeros, tag, value
// - flag set if any channel violates limits
// - tag zero for first input, one second
// - limit words use 12 low bits only
// - upper limits reset full, lower reset zero
// - result above upper limit raises event
// - upper event clears hysteresis below limit
// - result below lower limit raises event
// - lower event clears hysteresis above limit
// - one hysteresis per channel, both limits
// - hysteresis resets to eight
// - event shown in flag, pin per role
// - polarity bit zero means active low
// - two sticky status bits per channel
// - hysteresis all ones: limits track max/min
module alam_monitor #(
  parameter int DATA_W = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port, word wide, pointer addressed
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // results from the converter
  input wire logic conv_valid,
  input wire logic conv_chan,
  input wire logic [DATA_W-1:0] conv_data,
  input wire logic conv_busy,
  // converter control
  output logic conv_run,
  output logic conv_chan_sel,
  output logic ref_external,
  output logic bus_filter_en,
  // shared alert or busy pin
  output logic alert_busy_pin
);
  alam_lim_if #(.W(DATA_W)) lim ();

  // elaboration check: the result word has room for 12 value bits only
  if (DATA_W != alam_pkg::DATA_W)
  begin : g_bad_width
    $error("result layout serves only a 12-bit value");
  end

  // true when a pointer addresses the limit bank
  function automatic logic is_lim(input logic [3:0] a);
    return a >= alam_pkg::PTR_LO_CH1 && a <= alam_pkg::PTR_HY_CH2;
  endfunction

  // select code to {run, channel, external reference}
  function automatic logic [2:0] decode_sel(input logic [2:0] s,
                                            input logic seq);
    case (s)
      alam_pkg::SEL_IN1_VDD: return 3'b100;
      alam_pkg::SEL_IN1_EXT: return 3'b101;
      alam_pkg::SEL_IN2_VDD: return 3'b110;
      alam_pkg::SEL_ALT: return {1'b1, seq, 1'b0};
      default: return 3'b000; // no conversion
    endcase
  endfunction

  // state
  logic [alam_pkg::CFG_W-1:0] cfg_q; // configuration
  logic [7:0] cyc_q; // cycle timer, stored only
  logic [3:0] status_q; // sticky violation bits
  logic [alam_pkg::NUM_CH-1:0] hi_act_q; // upper event active
  logic [alam_pkg::NUM_CH-1:0] lo_act_q; // lower event active
  logic seq_ch_q; // next channel in alternation
  logic cmp_vld_q; // result waiting for comparison
  logic cmp_ch_q;
  logic [DATA_W-1:0] cmp_res_q;
  logic [DATA_W-1:0] last_res_q; // value in the result word
  logic last_tag_q; // channel of that value
  logic rd_pend_q; // read in flight
  logic [3:0] rd_addr_q;
  logic [15:0] own_q; // captured non-bank read data
  logic pin_q;
  logic run_q;
  logic chsel_q;
  logic refx_q;

  // decode of register port
  logic wr_cfg; // configuration write
  logic wr_status; // alert status write
  logic wr_cycle;
  logic clear_all; // role field written 11
  logic status_clr;
  logic [1:0] role_wr;
  logic [1:0] role_keep; // value stored for the role field
  alam_pkg::alam_role_t role;
  logic [2:0] sel;
  logic [2:0] dec;
  assign wr_cfg = reg_wr && reg_addr == alam_pkg::PTR_CONFIG;
  assign wr_status = reg_wr && reg_addr == alam_pkg::PTR_STATUS;
  assign wr_cycle = reg_wr && reg_addr == alam_pkg::PTR_CYCLE;
  assign role_wr = reg_wdata[alam_pkg::CFG_ROLE_HI:alam_pkg::CFG_ROLE_LO];
  assign clear_all = wr_cfg && role_wr == alam_pkg::ROLE_CLEAR;
  assign role_keep = clear_all ? alam_pkg::ROLE_ALERT : role_wr;
  assign status_clr = clear_all ||
    (wr_status && reg_wdata[7:0] == alam_pkg::STATUS_CLR_ALL);
  assign role = alam_pkg::alam_role_t'(
    cfg_q[alam_pkg::CFG_ROLE_HI:alam_pkg::CFG_ROLE_LO]);
  assign sel = cfg_q[alam_pkg::CFG_SEL_HI:alam_pkg::CFG_SEL_LO];
  assign dec = decode_sel(sel, seq_ch_q);

  // bank connections
  assign lim.sel_ch = conv_chan;
  assign lim.wr_en = reg_wr && is_lim(reg_addr);
  assign lim.wr_idx = 3'(reg_addr - alam_pkg::PTR_LO_CH1);
  assign lim.wr_data = reg_wdata[DATA_W-1:0];
  assign lim.rd_idx = 3'(reg_addr - alam_pkg::PTR_LO_CH1);

  // comparison of the pending result with its channel's triplet
  logic minmax; // hysteresis all ones
  logic over; // above upper limit
  logic under; // below lower limit
  logic hi_ok; // at least hysteresis below upper
  logic lo_ok; // at least hysteresis above lower
  logic [DATA_W:0] res_plus_hy;
  logic [DATA_W:0] lo_plus_hy;
  logic ev_hi;
  logic ev_lo;
  logic viol_flag;
  assign minmax = lim.hy == alam_pkg::HYST_MINMAX;
  assign over = cmp_res_q > lim.hi;
  assign under = cmp_res_q < lim.lo;
  assign res_plus_hy = {1'b0, cmp_res_q} + {1'b0, lim.hy};
  assign lo_plus_hy = {1'b0, lim.lo} + {1'b0, lim.hy};
  assign hi_ok = res_plus_hy <= {1'b0, lim.hi};
  assign lo_ok = {1'b0, cmp_res_q} >= lo_plus_hy;
  assign ev_hi = cmp_vld_q && !minmax && over;
  assign ev_lo = cmp_vld_q && !minmax && under;
  assign viol_flag = |{hi_act_q, lo_act_q};
  assign lim.upd_hi = cmp_vld_q && minmax && over;
  assign lim.upd_lo = cmp_vld_q && minmax && under;
  assign lim.upd_ch = cmp_ch_q;
  assign lim.upd_val = cmp_res_q;

  // result word and own read mux
  logic [15:0] result_word;
  logic [15:0] own_mux;
  assign result_word = {viol_flag, 2'b00, last_tag_q, last_res_q};
  always_comb
  begin
    case (reg_addr)
      alam_pkg::PTR_RESULT: own_mux = result_word;
      alam_pkg::PTR_STATUS: own_mux = {12'h000, status_q};
      alam_pkg::PTR_CONFIG: own_mux = {9'h000, cfg_q};
      alam_pkg::PTR_CYCLE: own_mux = {8'h00, cyc_q};
      default: own_mux = 16'h0000; // bank or unmapped
    endcase
  end

  // per-channel event state and sticky status, set beats clear
  for (genvar c = 0; c < alam_pkg::NUM_CH; c++)
  begin : g_ch
    logic mine; // pending result belongs to this channel
    logic set_hi;
    logic set_lo;
    logic rel_hi;
    logic rel_lo;
    assign mine = cmp_ch_q == 1'(c);
    assign set_hi = ev_hi && mine;
    assign set_lo = ev_lo && mine;
    assign rel_hi = cmp_vld_q && mine && !minmax && hi_ok;
    assign rel_lo = cmp_vld_q && mine && !minmax && lo_ok;
    always_ff @(posedge clk_sys)
    begin
      if (!rst_n)
      begin
        hi_act_q[c] <= 1'b0;
        lo_act_q[c] <= 1'b0;
        status_q[2*c] <= 1'b0;
        status_q[2*c+1] <= 1'b0;
      end
      else
      begin
        hi_act_q[c] <= set_hi || (hi_act_q[c] && !rel_hi && !clear_all);
        lo_act_q[c] <= set_lo || (lo_act_q[c] && !rel_lo && !clear_all);
        status_q[2*c] <= set_lo || (status_q[2*c] && !status_clr);
        status_q[2*c+1] <= set_hi || (status_q[2*c+1] && !status_clr);
      end
    end
  end

  // configuration, cycle timer and alternation
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cfg_q <= alam_pkg::CFG_RST;
      cyc_q <= alam_pkg::CYCLE_RST;
      seq_ch_q <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg_q <= {reg_wdata[alam_pkg::CFG_SEL_HI:alam_pkg::CFG_FLTR],
                  role_keep, reg_wdata[alam_pkg::CFG_POL]};
      if (wr_cycle)
        cyc_q <= reg_wdata[7:0];
      if (wr_cfg)
        seq_ch_q <= 1'b0; // alternation restarts on the first input
      else if (conv_valid && sel == alam_pkg::SEL_ALT)
        seq_ch_q <= !seq_ch_q;
    end
  end

  // result pipeline: capture, then compare against fetched triplet
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cmp_vld_q <= 1'b0;
      cmp_ch_q <= 1'b0;
      cmp_res_q <= '0;
      last_res_q <= '0;
      last_tag_q <= 1'b0;
    end
    else
    begin
      cmp_vld_q <= conv_valid;
      cmp_ch_q <= conv_chan;
      cmp_res_q <= conv_data;
      if (cmp_vld_q)
      begin
        last_res_q <= cmp_res_q;
        last_tag_q <= cmp_ch_q;
      end
    end
  end

  // two-stage read answer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= 4'h0;
      own_q <= 16'h0000;
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      rd_pend_q <= reg_rd;
      rd_addr_q <= reg_addr;
      own_q <= own_mux;
      reg_rvalid <= rd_pend_q;
      if (rd_pend_q)
        reg_rdata <= is_lim(rd_addr_q) ?
          {4'h0, lim.rd_data} : own_q;
    end
  end

  // pin role and polarity, converter control outputs
  logic pin_act;
  assign pin_act = (role == alam_pkg::ROLE_ALERT) ? viol_flag :
                   (role == alam_pkg::ROLE_BUSY) ? conv_busy : 1'b0;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pin_q <= 1'b1; // inactive for the reset polarity, active low
      run_q <= 1'b0;
      chsel_q <= 1'b0;
      refx_q <= 1'b0;
    end
    else
    begin
      pin_q <= cfg_q[alam_pkg::CFG_POL] ? pin_act : !pin_act;
      run_q <= dec[2];
      chsel_q <= dec[1];
      refx_q <= dec[0];
    end
  end
  assign alert_busy_pin = pin_q;
  assign conv_run = run_q;
  assign conv_chan_sel = chsel_q;
  assign ref_external = refx_q;
  assign bus_filter_en = cfg_q[alam_pkg::CFG_FLTR];

  alam_lim_bank #(.W(DATA_W)) u_bank (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .lim(lim)
  );

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_rd_req;
    reg_rd && !reg_wr;
  endsequence
  sequence s_answer;
    ##2 reg_rvalid;
  endsequence

  property p_role_back;
    clear_all |=> role == alam_pkg::ROLE_ALERT;
  endproperty
  a_role_back: assert property (p_role_back)
    else $error("role did not read back as alert after clear");

  property p_clear;
    clear_all && !cmp_vld_q |=> !viol_flag && status_q == 4'h0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear left flag or status set");

  property p_hi_event;
    ev_hi |=> hi_act_q[$past(cmp_ch_q)] && viol_flag;
  endproperty
  a_hi_event: assert property (p_hi_event)
    else $error("upper event not raised");

  property p_lo_event;
    ev_lo |=> lo_act_q[$past(cmp_ch_q)] && status_q != 4'h0;
  endproperty
  a_lo_event: assert property (p_lo_event)
    else $error("lower event not raised");

  property p_hi_hold;
    hi_act_q[0] && !clear_all && !(cmp_vld_q && !cmp_ch_q && hi_ok)
      |=> hi_act_q[0];
  endproperty
  a_hi_hold: assert property (p_hi_hold)
    else $error("upper event released inside hysteresis");

  property p_pol;
    role == alam_pkg::ROLE_ALERT && viol_flag && !cfg_q[alam_pkg::CFG_POL]
      && $stable(cfg_q) |=> !alert_busy_pin;
  endproperty
  a_pol: assert property (p_pol)
    else $error("active low alert pin not low");

  property p_tag;
    conv_valid ##1 cmp_vld_q |=> last_tag_q == $past(conv_chan, 2);
  endproperty
  a_tag: assert property (p_tag)
    else $error("channel tag does not match result channel");

  property p_alt;
    conv_valid && !wr_cfg && sel == alam_pkg::SEL_ALT
      |=> ##1 conv_chan_sel != $past(conv_chan_sel);
  endproperty
  a_alt: assert property (p_alt)
    else $error("alternation did not switch input");

  property p_sticky;
    status_q[1] && !status_clr |=> status_q[1];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("status bit lost without clear");

  property p_result_rd;
    s_rd_req ##0 reg_addr == alam_pkg::PTR_RESULT
      |-> s_answer ##0 reg_rdata[14:13] == 2'b00;
  endproperty
  a_result_rd: assert property (p_result_rd)
    else $error("result read late or zero bits set");
endmodule
`default_nettype wire

// ---- alam_conv_model.sv ----
// converter stand-in: delivers one result per command, prompt or slow
`timescale 1ns/100ps
`default_nettype none
module alam_conv_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // commands from the bench
  input wire logic go,
  input wire logic slow,
  input wire logic [11:0] go_data,
  // converter control from the monitor
  input wire logic conv_run,
  input wire logic conv_chan_sel,
  // results towards the monitor
  output logic conv_valid,
  output logic conv_chan,
  output logic [11:0] conv_data,
  output logic conv_busy
);
  int cnt; // cycles left in the conversion
  logic [11:0] hold; // value being converted
  // busy span, then a one-cycle result on the selected channel
  always_ff @(posedge clk_sys)
  begin
    conv_valid <= 1'b0;
    if (!rst_n)
    begin
      cnt <= 0;
      hold <= 12'h000;
      conv_busy <= 1'b0;
      conv_chan <= 1'b0;
      conv_data <= 12'h000;
    end
    else if (go && conv_run && cnt == 0)
    begin
      // start: slow mode stretches the busy span
      cnt <= slow ? 8 : 2;
      hold <= go_data;
      conv_busy <= 1'b1;
    end
    else if (cnt == 1)
    begin
      // finish: the result only stands in this cycle
      cnt <= 0;
      conv_busy <= 1'b0;
      conv_valid <= 1'b1;
      conv_data <= hold;
      conv_chan <= conv_chan_sel;
    end
    else
    begin
      // idle or busy: no stale value left on the lines
      cnt <= (cnt > 1) ? cnt - 1 : 0;
      conv_data <= ~conv_data;
      conv_chan <= ~conv_chan;
    end
  end
endmodule
`default_nettype wire

// ---- alam_monitor_bench.sv ----
// self-checking bench for the limit alert monitor
`timescale 1ns/100ps
`default_nettype none
module alam_monitor_bench;
  // expected register answer
  typedef struct packed {logic [3:0] a; logic [15:0] v;} alam_exp_t;
  localparam logic [2:0] SELS [6] = '{3'h0, 3'h7, 3'h1, 3'h5, 3'h2, 3'h3};
  logic clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid, go, slow;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic conv_valid, conv_chan, conv_busy, conv_run, conv_chan_sel;
  logic [11:0] conv_data, go_data, rv;
  logic ref_external, bus_filter_en, alert_busy_pin;
  logic [2:0] sel; // select code under test
  logic run_e; // conversion expected for that code
  alam_exp_t exp_q[$]; // answers still owed
  alam_exp_t mon_e; // answer being compared
  int miscompares = 0;
  int tests_run = 0;
  logic [15:0] lfsr_q = 16'h5027; // random state
  // device under test
  alam_monitor i_alam_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_data(conv_data),
    .conv_busy(conv_busy), .conv_run(conv_run),
    .conv_chan_sel(conv_chan_sel), .ref_external(ref_external),
    .bus_filter_en(bus_filter_en), .alert_busy_pin(alert_busy_pin));
  // converter on the far side
  alam_conv_model i_alam_conv_model (.clk_sys(clk_sys), .rst_n(rst_n),
    .go(go), .slow(slow), .go_data(go_data), .conv_run(conv_run),
    .conv_chan_sel(conv_chan_sel), .conv_valid(conv_valid),
    .conv_chan(conv_chan), .conv_data(conv_data), .conv_busy(conv_busy));
  // 40 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // sixteen-bit shift register step
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // configuration word: select, pin role, polarity, filter on
  function automatic logic [15:0] cfg(input logic [2:0] s,
    input logic [1:0] r, input logic p);
    return {9'h000, s, 1'b1, r, p};
  endfunction
  // step to just after a rising edge
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  // one comparison
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] s);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic pin(input logic e);
    chk("alert_busy_pin", {15'h0, e}, {15'h0, alert_busy_pin});
  endtask
  // register write, one-cycle strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    cyc();
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc();
    reg_wr = 1'b0;
  endtask
  // register read; expected answer noted for the watcher
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back({a, e});
    cyc();
    reg_addr = a;
    reg_rd = 1'b1;
    cyc();
    reg_rd = 1'b0;
    cyc(3);
  endtask
  // one conversion, then wait for the pin to follow
  task automatic conv(input logic [11:0] d);
    int n;
    cyc();
    go_data = d;
    go = 1'b1;
    cyc();
    go = 1'b0;
    for (n = 0; n < 20 && conv_valid !== 1'b1; n++)
      cyc();
    chk("conv_valid", 16'h0001, {15'h0, conv_valid});
    cyc(4);
  endtask
  // verdict and end of run
  task automatic complete_run;
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watcher: each answer against the oldest note
  always @(posedge clk_sys)
    if (reg_rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("spare answer", 16'h0000, 16'hFFFF);
      else
      begin
        mon_e = exp_q.pop_front();
        chk($sformatf("reg %h", mon_e.a), mon_e.v, reg_rdata);
      end
    end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    complete_run();
  end
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    go = 1'b0;
    slow = 1'b0;
    go_data = 12'h000;
    cyc(8);
    rst_n = 1'b1;
    // reset values, unmapped pointer
    rd(4'h2, 16'h0008);
    rd(4'h1, 16'h0000);
    rd(4'hA, 16'h0000);
    rd(4'h3, 16'h0000);
    chk("bus_filter_en", 16'h0001, {15'h0, bus_filter_en});
    wr(4'h2, 16'h0000);
    chk("bus_filter_en", 16'h0000, {15'h0, bus_filter_en});
    // cycle timer is stored and read back only
    wr(4'h3, 16'h00C3);
    rd(4'h3, 16'h00C3);
    for (int c = 0; c < 2; c++)
    begin
      rd(4'(4 + 3 * c), 16'h0000);
      rd(4'(5 + 3 * c), 16'h0FFF);
      rd(4'(6 + 3 * c), 16'h0008);
    end
    // every named select code and the unused code 7
    for (int i = 0; i < 6; i++)
    begin
      sel = SELS[i];
      run_e = sel inside {3'h1, 3'h2, 3'h3, 3'h5};
      wr(4'h2, cfg(sel, 2'b00, 1'b0));
      cyc(2);
      chk("conv_run", {15'h0, run_e}, {15'h0, conv_run});
      chk("ref_ext", {15'h0, sel == 3'h5}, {15'h0, ref_external});
      chk("chan_sel", {15'h0, sel == 3'h2}, {15'h0, conv_chan_sel});
    end
    // alternation starts on the first input
    conv(12'h300);
    rd(4'h0, 16'h0300);
    conv(12'h301);
    rd(4'h0, 16'h1301);
    // first channel limits, hysteresis 16
    wr(4'h5, 16'h0800);
    wr(4'h4, 16'h0100);
    wr(4'h6, 16'h0010);
    wr(4'h2, cfg(3'h1, 2'b10, 1'b0));
    conv(12'h800);
    pin(1'b1);
    conv(12'h801);
    pin(1'b0);
    rd(4'h0, 16'h8801);
    conv(12'h7F1);
    pin(1'b0);
    conv(12'h7F0);
    pin(1'b1);
    conv(12'h0FF);
    pin(1'b0);
    conv(12'h10F);
    pin(1'b0);
    conv(12'h110);
    pin(1'b1);
    rd(4'h1, 16'h0003);
    // first channel active, second channel result
    conv(12'h900);
    wr(4'h2, cfg(3'h2, 2'b10, 1'b0));
    conv(12'hFFF);
    rd(4'h0, 16'h9FFF);
    rd(4'h1, 16'h0003);
    // clear through the pin role bits
    wr(4'h2, cfg(3'h2, 2'b11, 1'b0));
    cyc(3);
    pin(1'b1);
    rd(4'h1, 16'h0000);
    rd(4'h0, 16'h1FFF);
    rd(4'h2, cfg(3'h2, 2'b10, 1'b0));
    // second channel event, polarity and role none
    wr(4'h8, 16'h0100);
    conv(12'h200);
    rd(4'h1, 16'h0008);
    wr(4'h2, cfg(3'h2, 2'b10, 1'b1));
    cyc(3);
    pin(1'b1);
    wr(4'h2, cfg(3'h2, 2'b00, 1'b1));
    cyc(3);
    pin(1'b0);
    rd(4'h0, 16'h9200);
    wr(4'h1, 16'h00FF);
    rd(4'h1, 16'h0000);
    // busy role during a slow conversion
    wr(4'h2, cfg(3'h2, 2'b01, 1'b0));
    slow = 1'b1;
    cyc();
    go_data = 12'h050;
    go = 1'b1;
    cyc();
    go = 1'b0;
    cyc(3);
    pin(1'b0);
    cyc(12);
    pin(1'b1);
    slow = 1'b0;
    // random limit word, then min/max tracking
    lfsr_q = lfsr_next(lfsr_q);
    wr(4'h7, lfsr_q);
    rd(4'h7, {4'h0, lfsr_q[11:0]});
    wr(4'h7, 16'h0600);
    wr(4'h8, 16'h0400);
    wr(4'h9, 16'h0FFF);
    wr(4'h2, cfg(3'h2, 2'b10, 1'b0));
    conv(12'h500);
    rd(4'h8, 16'h0500);
    rd(4'h7, 16'h0500);
    rd(4'h0, 16'h1500);
    wr(4'h0, 16'h0000);
    rd(4'h0, 16'h1500);
    // random in-range results on the first input
    wr(4'h2, cfg(3'h1, 2'b10, 1'b0));
    repeat (4)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      rv = 12'h200 + {2'b00, lfsr_q[9:0]};
      conv(rv);
      rd(4'h0, {4'h0, rv});
    end
    cyc(5);
    chk("answers owed", 16'h0000, 16'(exp_q.size()));
    complete_run();
  end
endmodule
`default_nettype wire
